// ==== core/rsc_defs.svh ====
// constants for the reset source control block
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RSC_CLK_PERIOD_NS 8
`define RSC_EXT_MIN_NS 2000
// least time, rounded up to whole cycles
`define RSC_EXT_MIN_CYC ((`RSC_EXT_MIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_EXT_CNT_W 9

// ----------------------------------------------------------------
// reset cause flag layout
// ----------------------------------------------------------------
`define RSC_FLAG_W 8
`define RSC_FLAG_LVD_BIT 0
`define RSC_FLAG_WDT_BIT 4
`define RSC_FLAG_RESET 8'h00

`endif

// ==== core/rsc_pkg.sv ====
// types for the reset source control block
package rsc_pkg;

  // ----------------------------------------------------------------
  // reset requests gathered from all sources
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ext;
    logic port;
    logic lvd;
    logic wdt;
  } rsc_req_s;

  // ----------------------------------------------------------------
  // shared pin window after power-on clear
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_WIN_OPEN = 2'h0,
    RSC_WIN_HOLD = 2'h1,
    RSC_WIN_CLOSED = 2'h2
  } rsc_win_e;

endpackage

// ==== core/rsc_low_filter.sv ====
// low-level width filter for the external reset pin
`timescale 1ns/10ps
`default_nettype none

module rsc_low_filter #(
  parameter int CNT_W = 9,
  parameter logic [CNT_W-1:0] MIN_CYC = 9'h0FA
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic pin_n,
  output logic accepted
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic acc_reg;
  logic acc_next;

  // ----------------------------------------------------------------
  // count low cycles, accept once the minimum width is reached
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    if (!enable || pin_n) begin
      cnt_next = '0;
      acc_next = 1'b0;
    end else if (cnt_reg < MIN_CYC - 1'b1) begin
      cnt_next = cnt_reg + 1'b1;
    end else begin
      acc_next = 1'b1; // held while the pin stays low
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      acc_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
    end
  end

  assign accepted = acc_reg;

  // accepted only after the full low width
  property p_min_width;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(acc_reg) |-> (cnt_reg == MIN_CYC - 1'b1) && $past(!pin_n);
  endproperty
  a_min_width: assert property (p_min_width) else $error("pin accepted too early");

endmodule

`default_nettype wire

// ==== core/rsc_top.sv ====
// reset source control: merges reset sources, keeps reset cause flags
`timescale 1ns/10ps
`include "rsc_defs.svh"
`default_nettype none

// Behaviour
// - shared pin low in window forces reset
// - detector reset spares the detector itself
// - watchdog overflow also resets the watchdog
// - power-on clear zeroes all cause flags
module rsc_top #(
  parameter int EXT_CNT_W = `RSC_EXT_CNT_W,
  parameter int EXT_MIN_CYC = `RSC_EXT_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic pin_is_port,
  input wire logic option_reload,
  input wire logic low_voltage_detector_req,
  input wire logic wdt_overflow,
  input wire logic flag_rd,
  output logic int_rst,
  output logic lvd_rst,
  output logic wdt_rst,
  output logic [`RSC_FLAG_W-1:0] reset_cause_flags,
  output logic [`RSC_FLAG_W-1:0] flag_rd_data,
  output logic port_pin_level
);

  // ----------------------------------------------------------------
  // external pin filter
  // ----------------------------------------------------------------
  logic ext_accepted;

  rsc_low_filter #(
    .CNT_W(EXT_CNT_W),
    .MIN_CYC(EXT_CNT_W'(EXT_MIN_CYC))
  ) u_ext_filter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(!pin_is_port),
    .pin_n(reset_pin_n),
    .accepted(ext_accepted)
  );

  // ----------------------------------------------------------------
  // shared pin window after power-on clear
  // ----------------------------------------------------------------
  rsc_pkg::rsc_win_e win_reg;
  rsc_pkg::rsc_win_e win_next;

  // open after power-on clear, hold on low pin, close on option reload
  always_comb begin
    win_next = win_reg;
    case (win_reg)
      rsc_pkg::RSC_WIN_OPEN: begin
        if (pin_is_port && !reset_pin_n) begin
          win_next = rsc_pkg::RSC_WIN_HOLD;
        end else if (option_reload) begin
          win_next = rsc_pkg::RSC_WIN_CLOSED;
        end
      end
      rsc_pkg::RSC_WIN_HOLD: begin
        if (reset_pin_n) begin
          win_next = rsc_pkg::RSC_WIN_OPEN;
        end
      end
      rsc_pkg::RSC_WIN_CLOSED: begin
        win_next = rsc_pkg::RSC_WIN_CLOSED;
      end
      default: begin
        win_next = rsc_pkg::RSC_WIN_OPEN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      win_reg <= rsc_pkg::RSC_WIN_OPEN;
    end else begin
      win_reg <= win_next;
    end
  end

  // ----------------------------------------------------------------
  // request gathering
  // ----------------------------------------------------------------
  rsc_pkg::rsc_req_s req;

  // current requests from every source
  always_comb begin
    req.ext = ext_accepted;
    req.port = (win_next == rsc_pkg::RSC_WIN_HOLD);
    req.lvd = low_voltage_detector_req;
    req.wdt = wdt_overflow;
  end

  // ----------------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------------
  logic int_rst_reg;
  logic int_rst_next;
  logic lvd_rst_reg;
  logic lvd_rst_next;
  logic wdt_rst_reg;
  logic wdt_rst_next;
  logic port_lvl_reg;
  logic port_lvl_next;

  // merge the sources into the three reset domains
  always_comb begin
    int_rst_next = req.ext | req.port | req.lvd | req.wdt;
    lvd_rst_next = req.ext | req.port | req.wdt;
    wdt_rst_next = req.ext | req.port | req.lvd | req.wdt;
    port_lvl_next = pin_is_port & reset_pin_n;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      int_rst_reg <= 1'b1;
      lvd_rst_reg <= 1'b1;
      wdt_rst_reg <= 1'b1;
      port_lvl_reg <= 1'b0;
    end else begin
      int_rst_reg <= int_rst_next;
      lvd_rst_reg <= lvd_rst_next;
      wdt_rst_reg <= wdt_rst_next;
      port_lvl_reg <= port_lvl_next;
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  logic [`RSC_FLAG_W-1:0] flags_reg;
  logic [`RSC_FLAG_W-1:0] flags_next;
  logic [`RSC_FLAG_W-1:0] rd_reg;
  logic [`RSC_FLAG_W-1:0] rd_next;

  // byte read returns and clears, a new cause wins over the clear
  always_comb begin
    flags_next = flags_reg;
    rd_next = rd_reg;
    if (flag_rd) begin
      rd_next = flags_reg;
      flags_next = `RSC_FLAG_RESET;
    end
    if (req.lvd) begin
      flags_next[`RSC_FLAG_LVD_BIT] = 1'b1;
    end
    if (req.wdt) begin
      flags_next[`RSC_FLAG_WDT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_reg <= `RSC_FLAG_RESET;
      rd_reg <= `RSC_FLAG_RESET;
    end else begin
      flags_reg <= flags_next;
      rd_reg <= rd_next;
    end
  end

  assign int_rst = int_rst_reg;
  assign lvd_rst = lvd_rst_reg;
  assign wdt_rst = wdt_rst_reg;
  assign port_pin_level = port_lvl_reg;
  assign reset_cause_flags = flags_reg;
  assign flag_rd_data = rd_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_port_low_in_window;
    pin_is_port && !reset_pin_n && (win_reg == rsc_pkg::RSC_WIN_OPEN);
  endsequence

  sequence s_held_until_high;
    int_rst_reg [*2];
  endsequence

  property p_port_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      s_port_low_in_window ##1 !reset_pin_n |=> s_held_until_high;
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("shared pin reset not held");

  property p_port_closed;
    @(posedge clk_sys) disable iff (sys_rst)
      (win_reg == rsc_pkg::RSC_WIN_CLOSED) && !low_voltage_detector_req && !wdt_overflow
      && !ext_accepted |=> !int_rst_reg;
  endproperty
  a_port_closed: assert property (p_port_closed) else $error("reset after window closed");

  property p_lvd_spared;
    @(posedge clk_sys) disable iff (sys_rst)
      low_voltage_detector_req && !wdt_overflow && !ext_accepted && !pin_is_port
      && (win_next != rsc_pkg::RSC_WIN_HOLD) |=> int_rst_reg && !lvd_rst_reg;
  endproperty
  a_lvd_spared: assert property (p_lvd_spared) else $error("detector reset itself");

  property p_wdt_self;
    @(posedge clk_sys) disable iff (sys_rst)
      wdt_overflow |=> wdt_rst_reg && lvd_rst_reg && flags_reg[`RSC_FLAG_WDT_BIT];
  endproperty
  a_wdt_self: assert property (p_wdt_self) else $error("watchdog not reset");

  property p_poc_clear;
    @(posedge clk_sys) sys_rst |=> (flags_reg == 8'h00) && int_rst_reg;
  endproperty
  a_poc_clear: assert property (p_poc_clear) else $error("flags not cleared");

  property p_merge;
    @(posedge clk_sys) disable iff (sys_rst)
      !$past(sys_rst) |-> int_rst_reg == $past(int_rst_next);
  endproperty
  a_merge: assert property (p_merge) else $error("internal reset mismatch");

  property p_idle;
    @(posedge clk_sys) disable iff (sys_rst)
      !ext_accepted && !low_voltage_detector_req && !wdt_overflow
      && (win_next != rsc_pkg::RSC_WIN_HOLD) |=> !int_rst_reg;
  endproperty
  a_idle: assert property (p_idle) else $error("reset without request");

  property p_set_wins;
    @(posedge clk_sys) disable iff (sys_rst)
      flag_rd && low_voltage_detector_req |=> flags_reg[`RSC_FLAG_LVD_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost on read");

endmodule

`default_nettype wire

// ==== tb/rsc_pin_src.sv ====
// board-side source that pulls the reset pin low
`timescale 1ns/10ps
`default_nettype none

module rsc_pin_src (
  input wire logic clk_sys,
  output logic pin_n
);
  // ------------------------------------------------
  // pin drive
  // ------------------------------------------------
  // released pin rests at the pull-up level
  initial begin
    pin_n = 1'h1;
  end

  // hold the pin low for whole cycles, then let the pull-up win
  task automatic hold_low(input int n);
    pin_n <= 1'h0;
    repeat (n) @(posedge clk_sys);
    pin_n <= 1'h1;
  endtask
endmodule

`default_nettype wire

// ==== tb/reset_source_control_bench.sv ====
// self-checking bench for the reset source control block
`timescale 1ns/10ps
`include "rsc_defs.svh"
`default_nettype none

module reset_source_control_bench;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  localparam int MIN = 4;
  typedef struct packed {
    logic lvd;
    logic wdt;
    logic irst;
    logic lrst;
    logic wrst;
    logic [7:0] flg;
  } rsc_row_s;
  logic clk_sys;
  logic sys_rst;
  logic reset_pin_n;
  logic pin_is_port;
  logic option_reload;
  logic lvd_req;
  logic wdt_ovf;
  logic flag_rd;
  logic int_rst;
  logic lvd_rst;
  logic wdt_rst;
  logic [`RSC_FLAG_W-1:0] flags;
  logic [`RSC_FLAG_W-1:0] rd_data;
  logic port_lvl;
  int error_cnt = 0;
  int n_checks = 0;
  rsc_row_s rows [5] = '{{5'h00, 8'h00}, {5'h15, 8'h01}, {5'h0F, 8'h11},
                         {5'h1F, 8'h11}, {5'h00, 8'h11}};

  rsc_top #(.EXT_CNT_W(`RSC_EXT_CNT_W), .EXT_MIN_CYC(MIN)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .pin_is_port(pin_is_port), .option_reload(option_reload),
    .low_voltage_detector_req(lvd_req), .wdt_overflow(wdt_ovf), .flag_rd(flag_rd),
    .int_rst(int_rst), .lvd_rst(lvd_rst), .wdt_rst(wdt_rst),
    .reset_cause_flags(flags), .flag_rd_data(rd_data), .port_pin_level(port_lvl));
  rsc_pin_src u_src (.clk_sys(clk_sys), .pin_n(reset_pin_n));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic chk1(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // 125 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard
  initial begin
    repeat (2000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    pin_is_port = 1'h0;
    option_reload = 1'h0;
    lvd_req = 1'h0;
    wdt_ovf = 1'h0;
    flag_rd = 1'h0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1 chk1("int_rst", 1'h1, int_rst);
    chk8("flags", 8'h00, flags);
    repeat (2) @(posedge clk_sys);
    #1 chk1("int_rst", 1'h0, int_rst);
    // request table, flags pile up
    foreach (rows[i]) begin
      @(posedge clk_sys);
      lvd_req <= rows[i].lvd;
      wdt_ovf <= rows[i].wdt;
      @(posedge clk_sys);
      #1 chk1("int_rst", rows[i].irst, int_rst);
      chk1("lvd_rst", rows[i].lrst, lvd_rst);
      chk1("wdt_rst", rows[i].wrst, wdt_rst);
      chk8("flags", rows[i].flg, flags);
    end
    // two byte reads back to back
    @(posedge clk_sys);
    flag_rd <= 1'h1;
    @(posedge clk_sys);
    #1 chk8("rd_data", 8'h11, rd_data);
    chk8("flags", 8'h00, flags);
    @(posedge clk_sys);
    flag_rd <= 1'h0;
    #1 chk8("rd_data", 8'h00, rd_data);
    // detector cause arriving with a read survives the clear
    @(posedge clk_sys);
    flag_rd <= 1'h1;
    lvd_req <= 1'h1;
    @(posedge clk_sys);
    lvd_req <= 1'h0;
    #1 chk8("flags", 8'h01, flags);
    chk8("rd_data", 8'h00, rd_data);
    @(posedge clk_sys);
    flag_rd <= 1'h0;
    #1 chk8("rd_data", 8'h01, rd_data);
    chk8("flags", 8'h00, flags);
    // pin low one cycle too short is ignored
    @(posedge clk_sys);
    u_src.hold_low(MIN - 1);
    repeat (6) begin
      @(posedge clk_sys);
      #1 chk1("int_rst", 1'h0, int_rst);
    end
    // long enough pin low is accepted
    @(posedge clk_sys);
    fork
      u_src.hold_low(MIN + 6);
      begin
        repeat (MIN + 3) @(posedge clk_sys);
        #1 chk1("int_rst", 1'h1, int_rst);
        chk1("wdt_rst", 1'h1, wdt_rst);
        chk8("flags", 8'h00, flags);
      end
    join
    repeat (4) @(posedge clk_sys);
    #1 chk1("int_rst", 1'h0, int_rst);
    // power-on clear wipes a watchdog flag
    @(posedge clk_sys);
    wdt_ovf <= 1'h1;
    @(posedge clk_sys);
    wdt_ovf <= 1'h0;
    #1 chk8("flags", 8'h10, flags);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    pin_is_port <= 1'h1;
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1 chk8("flags", 8'h00, flags);
    // shared pin: low in open window resets, closed window does not
    repeat (2) @(posedge clk_sys);
    @(posedge clk_sys);
    fork
      u_src.hold_low(6);
      begin
        repeat (5) @(posedge clk_sys);
        #1 chk1("int_rst", 1'h1, int_rst);
        chk1("port_lvl", 1'h0, port_lvl);
      end
    join
    repeat (2) @(posedge clk_sys);
    #1 chk1("int_rst", 1'h0, int_rst);
    chk1("port_lvl", 1'h1, port_lvl);
    @(posedge clk_sys);
    option_reload <= 1'h1;
    @(posedge clk_sys);
    option_reload <= 1'h0;
    fork
      u_src.hold_low(6);
      begin
        repeat (5) @(posedge clk_sys);
        #1 chk1("int_rst", 1'h0, int_rst);
        chk1("port_lvl", 1'h0, port_lvl);
      end
    join
    final_report();
  end
endmodule

`default_nettype wire
